// >>> design/rcso_pkg.sv
// Package of offsets, fields, reset values and timing for the reset-cause and options block
package rcso_pkg;

  // ----------------------------------------------------------------
  // Register indices on the CPU and debug register ports
  // ----------------------------------------------------------------
  localparam logic [1:0] RCSO_IDX_CAUSE = 2'h0;
  localparam logic [1:0] RCSO_IDX_FORCE = 2'h1;
  localparam logic [1:0] RCSO_IDX_OPTS  = 2'h2;

  // ----------------------------------------------------------------
  // Reset cause field positions and values
  // ----------------------------------------------------------------
  localparam int         RCSO_CAUSE_POR_BIT   = 7;
  localparam int         RCSO_CAUSE_PIN_BIT   = 6;
  localparam int         RCSO_CAUSE_WDOG_BIT  = 5;
  localparam int         RCSO_CAUSE_BADOP_BIT = 4;
  localparam int         RCSO_CAUSE_BADAD_BIT = 3;
  localparam int         RCSO_CAUSE_LOWV_BIT  = 1;
  localparam logic [7:0] RCSO_CAUSE_POR_VALUE = 8'h82;
  localparam logic [7:0] RCSO_CAUSE_MASK      = 8'hfa;

  // ----------------------------------------------------------------
  // Force-reset register
  // ----------------------------------------------------------------
  localparam int         RCSO_FORCE_BIT       = 0;
  localparam logic [7:0] RCSO_FORCE_READ      = 8'h00;

  // ----------------------------------------------------------------
  // Options register field positions and values
  // ----------------------------------------------------------------
  localparam int         RCSO_OPT_WDOG_EN_BIT = 7;
  localparam int         RCSO_OPT_TMO_BIT     = 6;
  localparam int         RCSO_OPT_STOP_BIT    = 5;
  localparam int         RCSO_OPT_RSVD_BIT    = 4;
  localparam int         RCSO_OPT_DBGPIN_BIT  = 1;
  localparam int         RCSO_OPT_RSTPIN_BIT  = 0;
  localparam logic [7:0] RCSO_OPTS_RESET      = 8'hd2;
  localparam logic [7:0] RCSO_OPTS_WMASK      = 8'hf3;
  localparam logic       RCSO_CLKSEL_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         RCSO_CLK_PERIOD_NS   = 10;
  localparam int         RCSO_HOLD_NS         = 160;
  localparam int         RCSO_HOLD_CYCLES     = (RCSO_HOLD_NS + RCSO_CLK_PERIOD_NS - 1)
                                                / RCSO_CLK_PERIOD_NS;
  localparam logic [15:0] RCSO_WDOG_BUS_SHORT = 16'h0400;
  localparam logic [15:0] RCSO_WDOG_BUS_LONG  = 16'h1000;
  localparam logic [15:0] RCSO_WDOG_KHZ_SHORT = 16'h0020;
  localparam logic [15:0] RCSO_WDOG_KHZ_LONG  = 16'h0100;

  // ----------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic {RCSO_ST_RUN, RCSO_ST_HOLD} rcso_state_t;

endpackage : rcso_pkg

// >>> design/rcso_watchdog.sv
// Watchdog counter with short/long period and bus or 1 kHz clock source
`timescale 1ns/10ps
module rcso_watchdog
  import rcso_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Control
  input  wire logic        restart_in,
  input  wire logic        enable_in,
  input  wire logic        long_sel_in,
  input  wire logic        bus_clk_sel_in,
  input  wire logic        tick_1khz_in,
  // Status
  output logic      [15:0] count_out,
  output logic             timeout_out
);

  logic [15:0] limit;
  logic        step;
  logic        at_end;

  // Period from timeout select and clock source
  always_comb begin
    if (bus_clk_sel_in) begin
      limit = long_sel_in ? RCSO_WDOG_BUS_LONG : RCSO_WDOG_BUS_SHORT;
    end else begin
      limit = long_sel_in ? RCSO_WDOG_KHZ_LONG : RCSO_WDOG_KHZ_SHORT;
    end
  end

  assign step   = bus_clk_sel_in | tick_1khz_in;
  assign at_end = (count_out == (limit - 16'h0001));

  // Counter: a disabled watchdog sits at zero
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_out <= 16'h0000;
    end else if (restart_in || !enable_in) begin
      count_out <= 16'h0000;
    end else if (step) begin
      count_out <= at_end ? 16'h0000 : count_out + 16'h0001;
    end
  end

  // Timeout pulse only while enabled
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timeout_out <= 1'b0;
    end else begin
      timeout_out <= enable_in && !restart_in && step && at_end;
    end
  end

  a_wdog_gated_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !enable_in |=> !timeout_out) else $error("watchdog fired while disabled");

endmodule : rcso_watchdog

// >>> design/rcso_sysctl.sv
// Reset cause latch, debug forced reset and write-once system options
// Notes on behaviour
// - Cause register read-only: bits 7,6,5,4,3,1 are sources; bits 2 and 0 read zero.
// - A debug forced reset clears every cause flag.
// - Writing the cause address restarts the watchdog and leaves flags alone.
// - Power-on sets power-on and low-voltage flags, clears the others.
// - Enabled low-voltage trip resets, sets low-voltage, keeps power-on, clears rest.
// - Other resets clear power-on and low-voltage, set flags of sources active at entry, and pin flag if pin goes low during hold.
// - Pin flag set when reset came from low level on the reset input.
// - Watchdog timeout resets only while the watchdog enable is set.
// - Bad opcode, disabled stop or disabled background instruction forces a reset.
// - Access at an unimplemented address forces a reset.
// - Force register writable only by debug commands; always reads zero.
// - Debug write of 1 to bit 0 of force register resets the device.
// - Options register takes only the first write after reset; always readable.
// - Options reset to d2; reset pin enable kept except after low-voltage.
// - Bit 7 enables the watchdog reset.
// - Bit 6 picks short or long watchdog period, with clock select.
// - Bit 1 routes shared pin to debug function; debug after every reset.
// - Bit 0 makes shared pin the reset input with pullup.
// - Bit 4 stores writes but does nothing.
// - Write-once clock select: 1 kHz tick when 0, bus clock when 1.
`timescale 1ns/10ps
module rcso_sysctl
  import rcso_pkg::*;
(
  // Clock and power-on reset
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // CPU register port
  input  wire logic [1:0] cpu_addr_in,
  input  wire logic       cpu_wr_in,
  input  wire logic       cpu_rd_in,
  input  wire logic [7:0] cpu_wdata_in,
  output logic      [7:0] cpu_rdata_out,
  // Background debug register port
  input  wire logic [1:0] dbg_addr_in,
  input  wire logic       dbg_wr_in,
  input  wire logic       dbg_rd_in,
  input  wire logic [7:0] dbg_wdata_in,
  output logic      [7:0] dbg_rdata_out,
  // Reset sources
  input  wire logic       reset_pin_n_in,
  input  wire logic       lvd_trip_in,
  input  wire logic       low_voltage_reset_enable_in,
  input  wire logic       opcode_unimpl_in,
  input  wire logic       stop_exec_in,
  input  wire logic       bgnd_exec_in,
  input  wire logic       background_mode_enable_in,
  input  wire logic       bad_address_in,
  input  wire logic       debug_mode_select_pin_in,
  // Watchdog clocking
  input  wire logic       tick_1khz_in,
  input  wire logic       watchdog_clock_select_in,
  input  wire logic       watchdog_clock_select_wr_in,
  // System outputs
  output logic            system_reset_out,
  output logic            bdm_entry_out,
  output logic            stop_enable_out,
  output logic            debug_pin_enable_out,
  output logic            reset_input_enable_out,
  output logic            reset_pullup_en_out,
  output logic            watchdog_timeout_out
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  rcso_state_t state;
  rcso_state_t next_state;
  logic [7:0]  hold_cnt;
  logic        hold_done;
  logic [7:0]  reset_cause_status;
  logic [7:0]  system_options_one;
  logic        opts_locked;
  logic        watchdog_clock_select;
  logic        clksel_locked;
  logic        pend_pin;
  logic        pend_wdog;
  logic        pend_badop;
  logic        pend_badad;
  logic        pend_lowv;
  logic        pend_dbg;
  logic [15:0] wd_count;
  logic        wd_timeout;

  // ----------------------------------------------------------------
  // Decode of sources and accesses
  // ----------------------------------------------------------------
  logic in_run;
  logic pin_rst;
  logic lvd_rst;
  logic badop_rst;
  logic dbg_force;
  logic any_src;
  logic entry_now;
  logic exit_now;
  logic cause_wr;
  logic opts_wr;
  logic [7:0] opts_wdata;

  assign in_run    = (state == RCSO_ST_RUN);
  // Pin counts only while it is configured as the reset input
  assign pin_rst   = system_options_one[RCSO_OPT_RSTPIN_BIT] && !reset_pin_n_in;
  assign lvd_rst   = low_voltage_reset_enable_in && lvd_trip_in;
  assign badop_rst = opcode_unimpl_in
                   || (stop_exec_in && !system_options_one[RCSO_OPT_STOP_BIT])
                   || (bgnd_exec_in && !background_mode_enable_in);
  // Only the debug port can reach the force bit; CPU writes there do nothing
  assign dbg_force = dbg_wr_in && (dbg_addr_in == RCSO_IDX_FORCE)
                   && dbg_wdata_in[RCSO_FORCE_BIT];
  assign any_src   = pin_rst || lvd_rst || wd_timeout || badop_rst
                   || bad_address_in || dbg_force;
  assign entry_now = in_run && any_src;
  assign exit_now  = (state == RCSO_ST_HOLD) && (next_state == RCSO_ST_RUN);
  assign hold_done = (hold_cnt == 8'(RCSO_HOLD_CYCLES - 1));

  // Either port writing the cause address kicks the watchdog
  assign cause_wr  = in_run && ((cpu_wr_in && (cpu_addr_in == RCSO_IDX_CAUSE))
                   || (dbg_wr_in && (dbg_addr_in == RCSO_IDX_CAUSE)));
  // Debug port wins when both ports write options in one cycle
  assign opts_wr    = in_run && ((cpu_wr_in && (cpu_addr_in == RCSO_IDX_OPTS))
                    || (dbg_wr_in && (dbg_addr_in == RCSO_IDX_OPTS)));
  assign opts_wdata = (dbg_wr_in && (dbg_addr_in == RCSO_IDX_OPTS)) ? dbg_wdata_in
                                                                     : cpu_wdata_in;

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  // Hold ends only after the minimum time and once pin and supply recover
  always_comb begin
    next_state = state;
    case (state)
      RCSO_ST_RUN: begin
        if (any_src) begin
          next_state = RCSO_ST_HOLD;
        end
      end
      RCSO_ST_HOLD: begin
        if (hold_done && !pin_rst && !lvd_rst) begin
          next_state = RCSO_ST_RUN;
        end
      end
      default: begin
        next_state = RCSO_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= RCSO_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Minimum hold time counter
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_cnt <= 8'h00;
    end else if (in_run) begin
      hold_cnt <= 8'h00;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  assign system_reset_out = (state == RCSO_ST_HOLD);

  // ----------------------------------------------------------------
  // Cause capture
  // ----------------------------------------------------------------
  // Sources sampled at entry; pin and supply may also extend the hold
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_pin   <= 1'b0;
      pend_wdog  <= 1'b0;
      pend_badop <= 1'b0;
      pend_badad <= 1'b0;
      pend_lowv  <= 1'b0;
      pend_dbg   <= 1'b0;
    end else if (entry_now) begin
      pend_pin   <= pin_rst;
      pend_wdog  <= wd_timeout;
      pend_badop <= badop_rst;
      pend_badad <= bad_address_in;
      pend_lowv  <= lvd_rst;
      pend_dbg   <= dbg_force;
    end else if (!in_run) begin
      pend_pin   <= pend_pin | pin_rst;
      pend_lowv  <= pend_lowv | lvd_rst;
    end
  end

  // Flags change only at reset release, so reads stay consistent
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reset_cause_status <= RCSO_CAUSE_POR_VALUE;
    end else if (exit_now) begin
      if (pend_dbg) begin
        reset_cause_status <= 8'h00;
      end else if (pend_lowv) begin
        reset_cause_status                      <= 8'h00;
        reset_cause_status[RCSO_CAUSE_POR_BIT]  <= reset_cause_status[RCSO_CAUSE_POR_BIT];
        reset_cause_status[RCSO_CAUSE_LOWV_BIT] <= 1'b1;
      end else begin
        reset_cause_status                       <= 8'h00;
        reset_cause_status[RCSO_CAUSE_PIN_BIT]   <= pend_pin;
        reset_cause_status[RCSO_CAUSE_WDOG_BIT]  <= pend_wdog;
        reset_cause_status[RCSO_CAUSE_BADOP_BIT] <= pend_badop;
        reset_cause_status[RCSO_CAUSE_BADAD_BIT] <= pend_badad;
      end
    end
  end

  // Mode pin is sampled as the forced reset releases
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bdm_entry_out <= 1'b0;
    end else if (exit_now) begin
      bdm_entry_out <= pend_dbg && !debug_mode_select_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Write-once options
  // ----------------------------------------------------------------
  // Lock closes on the first write; only a reset reopens it
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      system_options_one <= RCSO_OPTS_RESET;
      opts_locked        <= 1'b0;
    end else if (entry_now) begin
      system_options_one <= {RCSO_OPTS_RESET[7:1],
                             system_options_one[RCSO_OPT_RSTPIN_BIT] && !lvd_rst};
      opts_locked        <= 1'b0;
    end else if (!in_run) begin
      if (lvd_rst) begin
        system_options_one[RCSO_OPT_RSTPIN_BIT] <= 1'b0;
      end
    end else if (opts_wr && !opts_locked) begin
      system_options_one <= opts_wdata & RCSO_OPTS_WMASK;
      opts_locked        <= 1'b1;
    end
  end

  // Watchdog clock select, also write-once
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      watchdog_clock_select <= RCSO_CLKSEL_RESET;
      clksel_locked         <= 1'b0;
    end else if (entry_now) begin
      watchdog_clock_select <= RCSO_CLKSEL_RESET;
      clksel_locked         <= 1'b0;
    end else if (in_run && watchdog_clock_select_wr_in && !clksel_locked) begin
      watchdog_clock_select <= watchdog_clock_select_in;
      clksel_locked         <= 1'b1;
    end
  end

  // Pin routing; reserved bit 4 drives nothing
  assign stop_enable_out        = system_options_one[RCSO_OPT_STOP_BIT];
  assign debug_pin_enable_out   = system_options_one[RCSO_OPT_DBGPIN_BIT];
  assign reset_input_enable_out = system_options_one[RCSO_OPT_RSTPIN_BIT];
  assign reset_pullup_en_out    = system_options_one[RCSO_OPT_RSTPIN_BIT];
  assign watchdog_timeout_out   = wd_timeout;

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  rcso_watchdog u_wdog (
    .sys_clk_in     (sys_clk_in),
    .rstn_in        (rstn_in),
    .restart_in     (cause_wr || !in_run),
    .enable_in      (system_options_one[RCSO_OPT_WDOG_EN_BIT]),
    .long_sel_in    (system_options_one[RCSO_OPT_TMO_BIT]),
    .bus_clk_sel_in (watchdog_clock_select),
    .tick_1khz_in   (tick_1khz_in),
    .count_out      (wd_count),
    .timeout_out    (wd_timeout)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_mux(input logic [1:0] idx);
    case (idx)
      RCSO_IDX_CAUSE: rd_mux = reset_cause_status & RCSO_CAUSE_MASK;
      RCSO_IDX_FORCE: rd_mux = RCSO_FORCE_READ;
      RCSO_IDX_OPTS:  rd_mux = system_options_one;
      default:        rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // Read data one cycle after the strobe, held until the next read
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_rdata_out <= 8'h00;
    end else if (cpu_rd_in) begin
      cpu_rdata_out <= rd_mux(cpu_addr_in);
    end
  end

  // Debug reads work in any state
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dbg_rdata_out <= 8'h00;
    end else if (dbg_rd_in) begin
      dbg_rdata_out <= rd_mux(dbg_addr_in);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_cause_reserved_zero: assert property (
    cpu_rd_in && cpu_addr_in == RCSO_IDX_CAUSE |=> cpu_rdata_out[2] == 1'b0
      && cpu_rdata_out[0] == 1'b0) else $error("reserved cause bits not zero");

  a_debug_clears_flags: assert property (
    exit_now && pend_dbg |=> reset_cause_status == 8'h00)
    else $error("forced reset left flags");

  a_cause_write_keeps: assert property (
    cause_wr && !any_src |=> $stable(reset_cause_status) && wd_count == 16'h0000)
    else $error("cause write changed flags or missed watchdog");

  a_lowv_flag_update: assert property (
    exit_now && !pend_dbg && pend_lowv |=> reset_cause_status[RCSO_CAUSE_LOWV_BIT]
      && reset_cause_status[6:2] == 5'h00
      && reset_cause_status[RCSO_CAUSE_POR_BIT] == $past(reset_cause_status[RCSO_CAUSE_POR_BIT]))
    else $error("low voltage flags wrong");

  a_other_flag_update: assert property (
    exit_now && !pend_dbg && !pend_lowv |=> !reset_cause_status[RCSO_CAUSE_POR_BIT]
      && !reset_cause_status[RCSO_CAUSE_LOWV_BIT]
      && reset_cause_status[RCSO_CAUSE_PIN_BIT] == $past(pend_pin))
    else $error("other reset flags wrong");

  a_stop_illegal_reset: assert property (
    in_run && stop_exec_in && !stop_enable_out |=> system_reset_out && pend_badop)
    else $error("disabled stop did not reset");

  a_bad_address_reset: assert property (
    in_run && bad_address_in |=> system_reset_out && pend_badad)
    else $error("bad address did not reset");

  a_force_hold_time: assert property (
    in_run && dbg_force |=> system_reset_out [*8]) else $error("forced reset too short");

  a_options_once: assert property (
    in_run && opts_locked && opts_wr && !any_src |=> $stable(system_options_one))
    else $error("locked options changed");

  a_debug_pin_default: assert property (
    entry_now |=> debug_pin_enable_out && system_options_one[RCSO_OPT_WDOG_EN_BIT])
    else $error("options not defaulted on reset");

  c_debug_force: cover property (in_run && dbg_force ##[1:40] exit_now);
  c_wdog_reset: cover property (in_run && wd_timeout);
  c_opts_write: cover property (in_run && opts_wr && !opts_locked);
  c_lowv_exit: cover property (exit_now && pend_lowv);

endmodule : rcso_sysctl

// >>> tb/rcso_debug_host.sv
// Behavioural debug host driving the debug register port and the mode pin
`timescale 1ns/10ps
module rcso_debug_host
  import rcso_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_in,
  // Debug register port
  output logic      [1:0] dbg_addr_out,
  output logic            dbg_wr_out,
  output logic            dbg_rd_out,
  output logic      [7:0] dbg_wdata_out,
  // Mode pin, pulled up when the host lets go
  output logic            mode_pin_out
);
  initial begin
    dbg_addr_out  = 2'h3;
    dbg_wr_out    = 1'b0;
    dbg_rd_out    = 1'b0;
    dbg_wdata_out = 8'h00;
    mode_pin_out  = 1'b1;
  end

  // One write command; data is inverted afterwards so stale values never look valid
  task automatic dbg_write(input logic [1:0] a, input logic [7:0] d);
    dbg_addr_out  = a;
    dbg_wdata_out = d;
    dbg_wr_out    = 1'b1;
    @(posedge sys_clk_in);
    #1;
    dbg_wr_out    = 1'b0;
    dbg_wdata_out = ~d;
  endtask : dbg_write

  // Forced reset, mode pin set right after the command and held until released
  task automatic force_reset(input logic user_mode);
    dbg_write(RCSO_IDX_FORCE, 8'h01);
    mode_pin_out = user_mode;
  endtask : force_reset

  // One read command; the answer stands on the read port from the next edge
  task automatic dbg_read(input logic [1:0] a);
    dbg_addr_out = a;
    dbg_rd_out   = 1'b1;
    @(posedge sys_clk_in);
    #1;
    dbg_rd_out   = 1'b0;
  endtask : dbg_read

  task automatic mode_idle();
    mode_pin_out = 1'b1;
  endtask : mode_idle
endmodule : rcso_debug_host

// >>> tb/rcso_sysctl_bench.sv
// Self-checking bench for the reset cause latch and write-once options
`timescale 1ns/10ps
module rcso_sysctl_bench;
  import rcso_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       sys_clk_in, rstn_in, cpu_wr, cpu_rd, pin_n, low_voltage_flag, lvre, csel, csel_wr, dbg_wr;
  logic       dbg_rd, mode_pin, sys_rst, bdm, stop_en, dbgpin_en, rstin_en, pull_en, wdt;
  logic [1:0] cpu_addr, dbg_addr;
  logic [7:0] cpu_wdata, cpu_rdata, dbg_wdata, dbg_rdata;
  logic [3:0] src;
  int         num_errors, comparisons, wdt_seen;

  rcso_debug_host host (.sys_clk_in(sys_clk_in), .dbg_addr_out(dbg_addr), .dbg_wr_out(dbg_wr),
    .dbg_rd_out(dbg_rd), .dbg_wdata_out(dbg_wdata), .mode_pin_out(mode_pin));

  // Background mode enable and the 1 kHz tick are tied; the watchdog runs on the bus clock
  rcso_sysctl dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cpu_addr_in(cpu_addr),
    .cpu_wr_in(cpu_wr), .cpu_rd_in(cpu_rd), .cpu_wdata_in(cpu_wdata), .cpu_rdata_out(cpu_rdata),
    .dbg_addr_in(dbg_addr), .dbg_wr_in(dbg_wr), .dbg_rd_in(dbg_rd), .dbg_wdata_in(dbg_wdata),
    .dbg_rdata_out(dbg_rdata), .reset_pin_n_in(pin_n), .lvd_trip_in(low_voltage_flag),
    .low_voltage_reset_enable_in(lvre), .opcode_unimpl_in(src[0]), .stop_exec_in(src[1]),
    .bgnd_exec_in(src[2]), .background_mode_enable_in(1'b0), .bad_address_in(src[3]),
    .debug_mode_select_pin_in(mode_pin), .tick_1khz_in(1'b0), .watchdog_clock_select_in(csel),
    .watchdog_clock_select_wr_in(csel_wr), .system_reset_out(sys_rst), .bdm_entry_out(bdm),
    .stop_enable_out(stop_en), .debug_pin_enable_out(dbgpin_en),
    .reset_input_enable_out(rstin_en), .reset_pullup_en_out(pull_en),
    .watchdog_timeout_out(wdt));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Timeout pulses counted mid-cycle, away from the edge that launches them
  always @(negedge sys_clk_in) begin
    if (wdt === 1'b1) begin
      wdt_seen++;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks; every task starts and ends 1 ns after a rising edge
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    cpu_addr  = a;
    cpu_wdata = d;
    cpu_wr    = 1'b1;
    cyc(1);
    cpu_wr    = 1'b0;
    cpu_wdata = ~d;
    cyc(1); // Idle edge so back-to-back calls never flip a strobe in one step
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    cpu_addr = a;
    cpu_rd   = 1'b1;
    cyc(1);
    cpu_rd   = 1'b0;
    check(cpu_rdata, exp);
    cyc(1); // Idle edge so back-to-back calls never flip a strobe in one step
  endtask : rd

  // Cycles until reset rises, capped at lim
  task automatic to_rst(input int lim, output int n);
    n = 0;
    while (sys_rst !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : to_rst

  // Hold must last the chosen minimum, then the cause flags are read back
  task automatic wait_rst(input logic [7:0] exp);
    int n;
    to_rst(40, n);
    n = 0;
    while (sys_rst === 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    check(n >= RCSO_HOLD_CYCLES && sys_rst === 1'b0, 1'b1);
    rd(RCSO_IDX_CAUSE, exp);
  endtask : wait_rst

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    rd(RCSO_IDX_CAUSE, RCSO_CAUSE_POR_VALUE);
    rd(RCSO_IDX_OPTS, RCSO_OPTS_RESET);
    rd(RCSO_IDX_FORCE, 8'h00);
    rd(2'h3, 8'h00);
    check(dbgpin_en, 1'b1);
  endtask : t_power

  // Second option write must bounce; CPU cannot force a reset
  task automatic t_options();
    wr(RCSO_IDX_OPTS, 8'h21);
    rd(RCSO_IDX_OPTS, 8'h21);
    check({stop_en, rstin_en, pull_en, dbgpin_en}, 4'he);
    wr(RCSO_IDX_OPTS, 8'hd2);
    rd(RCSO_IDX_OPTS, 8'h21);
    host.dbg_read(RCSO_IDX_OPTS);
    check(dbg_rdata, 8'h21);
    wr(RCSO_IDX_CAUSE, 8'hff);
    rd(RCSO_IDX_CAUSE, RCSO_CAUSE_POR_VALUE);
    wr(RCSO_IDX_FORCE, 8'h01);
    cyc(20);
    check(sys_rst, 1'b0);
  endtask : t_options

  task automatic t_force();
    host.force_reset(1'b0);
    wait_rst(8'h00);
    check(bdm, 1'b1);
    host.dbg_read(RCSO_IDX_FORCE);
    check(dbg_rdata, 8'h00);
    rd(RCSO_IDX_OPTS, 8'hd3);
    check(dbgpin_en, 1'b1);
    host.mode_idle();
    wr(RCSO_IDX_OPTS, 8'h10);
    rd(RCSO_IDX_OPTS, 8'h10);
  endtask : t_force

  task automatic t_sources();
    for (int k = 0; k < 4; k++) begin
      src = 4'h1 << k;
      cyc(1);
      src = 4'h0;
      wait_rst((k == 3) ? 8'h08 : 8'h10);
    end
  endtask : t_sources

  task automatic t_lowv_pin();
    wr(RCSO_IDX_OPTS, 8'h01);
    lvre = 1'b1;
    low_voltage_flag  = 1'b1;
    cyc(1);
    low_voltage_flag  = 1'b0;
    wait_rst(8'h02);
    rd(RCSO_IDX_OPTS, RCSO_OPTS_RESET);
    lvre = 1'b0;
    wr(RCSO_IDX_OPTS, 8'h01);
    pin_n = 1'b0;
    cyc(1);
    pin_n = 1'b1;
    wait_rst(8'h40);
    check(rstin_en, 1'b1);
  endtask : t_lowv_pin

  // Disabled watchdog stays quiet; enabled one fires a short period after the last restart
  task automatic t_wdog();
    int n;
    csel    = 1'b1;
    csel_wr = 1'b1;
    cyc(1);
    csel_wr = 1'b0;
    wr(RCSO_IDX_OPTS, 8'h00);
    to_rst(1100, n);
    check(n == 1100, 1'b1);
    host.force_reset(1'b1);
    wait_rst(8'h00);
    check(bdm, 1'b0);
    csel_wr = 1'b1;
    cyc(1);
    csel_wr = 1'b0;
    wr(RCSO_IDX_OPTS, 8'h80);
    wr(RCSO_IDX_CAUSE, 8'h00);
    cyc(600);
    wr(RCSO_IDX_CAUSE, 8'h5a);
    to_rst(1100, n);
    check(n > 1015 && n < 1035, 1'b1);
    wait_rst(8'h20);
    check(8'(wdt_seen), 8'h01);
  endtask : t_wdog

  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    {rstn_in, cpu_wr, cpu_rd, low_voltage_flag, lvre, csel, csel_wr} = 7'h00;
    {cpu_addr, cpu_wdata, src, pin_n} = 15'h7f01;
    cyc(16);
    rstn_in = 1'b1;
    t_power();
    t_options();
    t_force();
    t_sources();
    t_lowv_pin();
    t_wdog();
    end_sim();
  end

  // Whole run is a few thousand cycles; a hang is cut off well beyond that
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : rcso_sysctl_bench
